// File: inc/ssr_pkg.sv
// Purpose: shared constants and types of the serial status reporter
// Assumes: 250 MHz system clock
// Notes:   character codes are plain ascii
package ssr_pkg;
  // ==========================================================
  // timing
  localparam int CLK_HZ          = 250_000_000;
  localparam int BAUD_RATE       = 2400;
  localparam int BIT_CYCLES      = (CLK_HZ + BAUD_RATE / 2) / BAUD_RATE;
  localparam int REPORT_PERIOD_S = 2;
  localparam int REPORT_CYCLES   = CLK_HZ * REPORT_PERIOD_S;
  // ==========================================================
  // frame and buffer
  localparam int DATA_BITS  = 8;
  localparam int FIFO_DEPTH = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] SEC_LAST = 3'h6;
  localparam logic RPT_EN_RESET   = 1'b1;
  // ==========================================================
  // characters
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_A  = 8'h61;
  localparam logic [7:0] CH_S  = 8'h73;
  localparam logic [7:0] CH_Z  = 8'h7A;
  localparam logic [7:0] CH_T  = 8'h74;
  // ==========================================================
  // states
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00, TX_START = 2'b01, TX_DATA = 2'b10, TX_STOP = 2'b11
  } ssr_tx_t;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_STOP = 2'b11
  } ssr_rx_t;
  typedef enum logic [1:0] {
    GEN_IDLE = 2'b00, GEN_TEXT = 2'b01, GEN_CR = 2'b10, GEN_LF = 2'b11
  } ssr_gen_t;
endpackage

// File: hw/ssr_fifo.sv
// Purpose: small first-in first-out buffer with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   read data comes straight from the storage flops
`timescale 1ns/1ps
module ssr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      wr_d;
  logic [AW:0]      rd_q;
  logic [AW:0]      rd_d;
  logic             push;
  logic             pop;

  // ==========================================================
  // pointers, one extra bit tells full from empty
  always_comb begin
    o_in_ready  = (wr_q - rd_q) != (AW + 1)'(DEPTH);
    o_out_valid = wr_q != rd_q;
    push        = i_in_valid && o_in_ready;
    pop         = o_out_valid && i_out_ready;
    wr_d        = wr_q + (AW + 1)'(push);
    rd_d        = rd_q + (AW + 1)'(pop);
  end

  assign o_out_data = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // storage needs no reset, nothing reads an empty slot
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= i_in_data;
    end
  end
endmodule

// File: hw/ssr_top.sv
// Purpose: serial status reporter, report sender and command receiver
// Assumes: report inputs come from this clock domain and hold during a report
// Notes:   the report generator stalls on the fifo, the transmitter drains it
//
// What this block does
// - link runs 2400 baud, eight data bits, no parity, one stop bit
// - transmitter and receiver run independently at the same time
// - while enabled, a fresh report starts every two seconds
// - report order: concentration, range word, span, disabled tags, tripped tags
// - every report item is followed by carriage return then line feed
// - autospan command plus enter starts a span calibration at once
// - autozero command plus enter starts a zero calibration at once
// - status toggle command plus enter inverts the report enable flag
`timescale 1ns/1ps
module ssr_top
  import ssr_pkg::*;
#(
  parameter int P_BIT_CYCLES    = BIT_CYCLES,
  parameter int P_REPORT_CYCLES = REPORT_CYCLES
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_rxd,
  output logic             o_txd,
  input  wire logic [15:0] i_conc_bcd,
  input  wire logic        i_conc_pct,
  input  wire logic [1:0]  i_range,
  input  wire logic [15:0] i_span_bcd,
  input  wire logic [1:0]  i_alarm_dis,
  input  wire logic [1:0]  i_alarm_trip,
  output logic             o_autospan_start,
  output logic             o_autozero_start,
  output logic             o_report_enable
);
  localparam logic [31:0] BIT_LAST = 32'(P_BIT_CYCLES - 1);
  localparam logic [31:0] BIT_HALF = 32'(P_BIT_CYCLES / 2 - 1);
  localparam logic [31:0] RPT_LAST = 32'(P_REPORT_CYCLES - 1);

  // ==========================================================
  // report text helpers
  function automatic logic [3:0] pick(input logic [15:0] v, input logic [1:0] k);
    case (k)
      2'h0:    pick = v[15:12];
      2'h1:    pick = v[11:8];
      2'h2:    pick = v[7:4];
      default: pick = v[3:0];
    endcase
  endfunction

  function automatic logic [7:0] dig(input logic [3:0] n);
    dig = 8'h30 | {4'h0, n};
  endfunction

  // returns {last character of item, character}
  function automatic logic [8:0] text_char(input logic [2:0] sec, input logic [3:0] idx,
                                           input logic [15:0] conc, input logic pct,
                                           input logic [1:0] rng, input logic [15:0] span);
    logic [7:0] ch;
    logic       lst;
    ch  = 8'h20;
    lst = 1'b0;
    case (sec)
      3'h0: begin
        case (idx)
          4'h0, 4'h1, 4'h2, 4'h3: ch = dig(pick(conc, idx[1:0]));
          4'h4: begin
            ch  = pct ? 8'h25 : 8'h50;
            lst = pct;
          end
          4'h5:    ch = 8'h50;
          default: begin
            ch  = 8'h4D;
            lst = 1'b1;
          end
        endcase
      end
      3'h1: begin
        case ({rng == 2'h2, rng == 2'h1, idx[1:0]})
          4'b1000: ch = 8'h48;
          4'b1001: ch = 8'h49;
          4'b0100: ch = 8'h4D;
          4'b0101: ch = 8'h45;
          4'b0110: ch = 8'h44;
          4'b0000: ch = 8'h4C;
          default: ch = 8'h4F;
        endcase
        lst = (rng == 2'h1) ? (idx == 4'h2) : (idx == 4'h1);
      end
      3'h2: begin
        case (idx)
          4'h0:    ch = 8'h30;
          4'h1:    ch = 8'h2D;
          default: ch = dig(pick(span, 2'(idx - 4'h2)));
        endcase
        lst = idx == 4'h5;
      end
      default: begin
        case (idx)
          4'h0:    ch = 8'h41;
          4'h1:    ch = 8'h4C;
          4'h2:    ch = 8'h2D;
          4'h3:    ch = sec[0] ? 8'h31 : 8'h32;
          4'h4:    ch = 8'h20;
          4'h5:    ch = (sec < 3'h5) ? 8'h44 : 8'h4F;
          4'h6:    ch = (sec < 3'h5) ? 8'h49 : 8'h4E;
          4'h7:    ch = 8'h53;
          4'h8:    ch = 8'h41;
          4'h9:    ch = 8'h42;
          4'hA:    ch = 8'h4C;
          4'hB:    ch = 8'h45;
          default: ch = 8'h44;
        endcase
        lst = (sec < 3'h5) ? (idx == 4'hC) : (idx == 4'h6);
      end
    endcase
    text_char = {lst, ch};
  endfunction

  // ==========================================================
  // interval timer and report generator
  ssr_gen_t   gen_q, gen_d;
  logic [2:0] sec_q, sec_d;
  logic [3:0] idx_q, idx_d;
  logic [31:0] tmr_q, tmr_d;
  logic       tmr_tick;
  logic       sec_on;
  logic [8:0] tc;
  logic       fifo_in_valid, fifo_in_ready, gen_push;
  logic [7:0] fifo_in_data;
  logic       rpt_en_q, rpt_en_d;

  always_comb begin
    tmr_tick = tmr_q == RPT_LAST;
    tmr_d    = tmr_tick ? '0 : tmr_q + 32'h1;
    tc       = text_char(sec_q, idx_q, i_conc_bcd, i_conc_pct, i_range, i_span_bcd);
    case (sec_q)
      3'h3:    sec_on = i_alarm_dis[0];
      3'h4:    sec_on = i_alarm_dis[1];
      3'h5:    sec_on = i_alarm_trip[0];
      3'h6:    sec_on = i_alarm_trip[1];
      default: sec_on = 1'b1;
    endcase
    fifo_in_valid = ((gen_q == GEN_TEXT) && sec_on) || (gen_q == GEN_CR) || (gen_q == GEN_LF);
    fifo_in_data  = (gen_q == GEN_CR) ? CH_CR : (gen_q == GEN_LF) ? CH_LF : tc[7:0];
    gen_push = fifo_in_valid && fifo_in_ready;
    gen_d = gen_q;
    sec_d = sec_q;
    idx_d = idx_q;
    case (gen_q)
      GEN_IDLE: if (tmr_tick && rpt_en_q) begin
        gen_d = GEN_TEXT;
        sec_d = '0;
        idx_d = '0;
      end
      GEN_TEXT: if (!sec_on) begin
        gen_d = (sec_q == SEC_LAST) ? GEN_IDLE : GEN_TEXT;
        sec_d = sec_q + 3'h1;
      end else if (gen_push) begin
        if (tc[8]) gen_d = GEN_CR;
        idx_d = idx_q + 4'h1;
      end
      GEN_CR: if (gen_push) gen_d = GEN_LF;
      GEN_LF: if (gen_push) begin
        gen_d = (sec_q == SEC_LAST) ? GEN_IDLE : GEN_TEXT;
        sec_d = sec_q + 3'h1;
        idx_d = '0;
      end
      default: gen_d = GEN_IDLE;
    endcase
  end

  // ==========================================================
  // buffer between generator and transmitter
  logic       fifo_out_valid, fifo_out_ready;
  logic [7:0] fifo_out_data;

  ssr_fifo #(.WIDTH(DATA_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_rst_b     (i_rst_b),
    .i_in_valid  (fifo_in_valid),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (fifo_in_data),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (fifo_out_ready),
    .o_out_data  (fifo_out_data)
  );

  // ==========================================================
  // transmitter, 8n1 frame
  ssr_tx_t    tx_q, tx_d;
  logic [31:0] tcnt_q, tcnt_d;
  logic [2:0] tbit_q, tbit_d;
  logic [7:0] tsh_q, tsh_d;
  logic       txd_q, txd_d, tx_tick;

  assign fifo_out_ready = tx_q == TX_IDLE;
  assign tx_tick        = tcnt_q == BIT_LAST;

  always_comb begin
    tx_d   = tx_q;
    tbit_d = tbit_q;
    tsh_d  = tsh_q;
    txd_d  = txd_q;
    tcnt_d = tx_tick ? '0 : tcnt_q + 32'h1;
    case (tx_q)
      TX_IDLE: begin
        tcnt_d = '0;
        if (fifo_out_valid) begin
          tsh_d = fifo_out_data;
          txd_d = 1'b0;
          tx_d  = TX_START;
        end
      end
      TX_START: if (tx_tick) begin
        tx_d   = TX_DATA;
        txd_d  = tsh_q[0];
        tbit_d = '0;
      end
      TX_DATA: if (tx_tick) begin
        if (tbit_q == LAST_BIT) begin
          tx_d  = TX_STOP;
          txd_d = 1'b1;
        end else begin
          tbit_d = tbit_q + 3'h1;
          tsh_d  = {1'b0, tsh_q[7:1]};
          txd_d  = tsh_q[1];
        end
      end
      TX_STOP: if (tx_tick) tx_d = TX_IDLE;
      default: tx_d = TX_IDLE;
    endcase
  end

  assign o_txd = txd_q;

  // ==========================================================
  // receiver, own divider so it runs beside the transmitter
  ssr_rx_t    rx_q, rx_d;
  logic [31:0] rcnt_q, rcnt_d;
  logic [2:0] rbit_q, rbit_d;
  logic [7:0] rsh_q, rsh_d;
  logic       s1_q, s2_q, s3_q, lvl_q, lvl_d, rx_stb;

  always_comb begin
    lvl_d  = (s2_q == s3_q) ? s3_q : lvl_q;
    rx_d   = rx_q;
    rbit_d = rbit_q;
    rsh_d  = rsh_q;
    rx_stb = 1'b0;
    rcnt_d = rcnt_q + 32'h1;
    case (rx_q)
      RX_IDLE: begin
        rcnt_d = '0;
        if (!lvl_q) rx_d = RX_START;
      end
      RX_START: if (rcnt_q == BIT_HALF) begin
        rcnt_d = '0;
        rbit_d = '0;
        rx_d   = lvl_q ? RX_IDLE : RX_DATA;
      end
      RX_DATA: if (rcnt_q == BIT_LAST) begin
        rcnt_d = '0;
        rsh_d  = {lvl_q, rsh_q[7:1]};
        rbit_d = rbit_q + 3'h1;
        if (rbit_q == LAST_BIT) rx_d = RX_STOP;
      end
      RX_STOP: if (rcnt_q == BIT_LAST) begin
        rx_d   = RX_IDLE;
        rx_stb = lvl_q;  // a low stop bit drops the character
      end
      default: rx_d = RX_IDLE;
    endcase
  end

  // ==========================================================
  // command line parser
  logic [7:0] c0_q, c0_d, c1_q, c1_d;
  logic [1:0] ccnt_q, ccnt_d;
  logic       is_cr, is_span, is_zero, is_tog;
  logic       span_q, zero_q;

  always_comb begin
    is_cr   = rx_stb && (rsh_q == CH_CR) && (ccnt_q == 2'h2);
    is_span = is_cr && (c1_q == CH_A) && (c0_q == CH_S);
    is_zero = is_cr && (c1_q == CH_A) && (c0_q == CH_Z);
    is_tog  = is_cr && (c1_q == CH_S) && (c0_q == CH_T);
    rpt_en_d = is_tog ? !rpt_en_q : rpt_en_q;
    c0_d   = c0_q;
    c1_d   = c1_q;
    ccnt_d = ccnt_q;
    // line feeds are skipped so a terminal sending cr lf still works
    if (rx_stb && (rsh_q == CH_CR)) begin
      ccnt_d = '0;
    end else if (rx_stb && (rsh_q != CH_LF)) begin
      c1_d   = c0_q;
      c0_d   = rsh_q;
      ccnt_d = (ccnt_q == 2'h3) ? ccnt_q : ccnt_q + 2'h1;
    end
  end

  assign o_autospan_start = span_q;
  assign o_autozero_start = zero_q;
  assign o_report_enable  = rpt_en_q;

  // ==========================================================
  // state registers
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      gen_q <= GEN_IDLE;  sec_q <= '0;  idx_q <= '0;  tmr_q <= '0;
      tx_q  <= TX_IDLE;  tcnt_q <= '0;  tbit_q <= '0;  tsh_q <= '0;  txd_q <= 1'b1;
      rx_q  <= RX_IDLE;  rcnt_q <= '0;  rbit_q <= '0;  rsh_q <= '0;
      s1_q  <= 1'b1;  s2_q <= 1'b1;  s3_q <= 1'b1;  lvl_q <= 1'b1;
      c0_q  <= '0;  c1_q <= '0;  ccnt_q <= '0;
      span_q <= 1'b0;  zero_q <= 1'b0;  rpt_en_q <= RPT_EN_RESET;
    end else begin
      gen_q <= gen_d;  sec_q <= sec_d;  idx_q <= idx_d;  tmr_q <= tmr_d;
      tx_q  <= tx_d;  tcnt_q <= tcnt_d;  tbit_q <= tbit_d;  tsh_q <= tsh_d;  txd_q <= txd_d;
      rx_q  <= rx_d;  rcnt_q <= rcnt_d;  rbit_q <= rbit_d;  rsh_q <= rsh_d;
      s1_q  <= i_rxd;  s2_q <= s1_q;  s3_q <= s2_q;  lvl_q <= lvl_d;
      c0_q  <= c0_d;  c1_q <= c1_d;  ccnt_q <= ccnt_d;
      span_q <= is_span;  zero_q <= is_zero;  rpt_en_q <= rpt_en_d;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  sequence cr_push_s;
    (gen_q == GEN_CR) && gen_push;
  endsequence
  sequence lf_next_s;
    (gen_q == GEN_LF) && (fifo_in_data == CH_LF);
  endsequence

  frame_start_a: assert property ((tx_q == TX_IDLE) && fifo_out_valid |=>
    (tx_q == TX_START) && !o_txd) else $error("start bit missing");
  stop_bit_a: assert property ((tx_q == TX_DATA) && tx_tick && (tbit_q == LAST_BIT) |=>
    (tx_q == TX_STOP) && o_txd) else $error("stop bit not after eighth bit");
  rx_wakeup_a: assert property ((rx_q == RX_IDLE) && !lvl_q |=>
    (rx_q == RX_START)) else $error("receiver missed start edge");
  report_start_a: assert property (tmr_tick && rpt_en_q && (gen_q == GEN_IDLE) |=>
    (gen_q == GEN_TEXT) && (sec_q == 3'h0) && (idx_q == 4'h0)) else $error("report not started");
  item_order_a: assert property ((gen_q == GEN_LF) && gen_push && (sec_q != SEC_LAST) |=>
    (sec_q == $past(sec_q) + 3'h1) && (idx_q == 4'h0)) else $error("item order broken");
  crlf_pair_a: assert property (cr_push_s |-> (fifo_in_data == CH_CR) ##1 lf_next_s)
    else $error("cr not followed by lf");
  span_cmd_a: assert property (is_span |=> o_autospan_start && !o_autozero_start ##1
    !o_autospan_start) else $error("autospan pulse wrong");
  zero_cmd_a: assert property (is_zero |=> o_autozero_start && !o_autospan_start ##1
    !o_autozero_start) else $error("autozero pulse wrong");
  toggle_cmd_a: assert property (is_tog |=> (o_report_enable != $past(o_report_enable)))
    else $error("report enable not toggled");
  quiet_off_a: assert property (!rpt_en_q && (gen_q == GEN_IDLE) |=> (gen_q == GEN_IDLE))
    else $error("report sent while disabled");
  discard_line_a: assert property (rx_stb && !is_span && !is_zero && !is_tog |=>
    !o_autospan_start && !o_autozero_start && $stable(o_report_enable))
    else $error("unknown line changed state");
endmodule

// File: bench/ssr_host.sv
// Purpose: host terminal model on the far side of the serial link
// Assumes: P_BIT_CYCLES matches the design instance, one clock domain
// Notes:   receive queues are read by the bench through hierarchy
`timescale 1ns/1ps
module ssr_host
  import ssr_pkg::*;
#(
  parameter int P_BIT_CYCLES = 16
) (
  input  wire logic i_sys_clk,
  input  wire logic i_txd,
  output logic      o_rxd
);
  // ==========================================================
  // receive side
  logic [7:0] rx_q[$];
  int         start_q[$];
  int         frame_err = 0;
  int         cyc       = 0;
  int         t_start;
  logic [7:0] shift;

  initial o_rxd = 1'b1;  // mark level while idle

  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
  end

  // sample at the falling edge so registered txd changes never race
  always begin
    @(negedge i_txd);
    t_start = cyc;
    repeat (P_BIT_CYCLES / 2) @(negedge i_sys_clk);
    if (i_txd !== 1'b0) frame_err++;  // start bit
    for (int i = 0; i < DATA_BITS; i++) begin
      repeat (P_BIT_CYCLES) @(negedge i_sys_clk);
      shift[i] = i_txd;  // lsb first, eight bits, no parity
    end
    repeat (P_BIT_CYCLES) @(negedge i_sys_clk);
    if (i_txd !== 1'b1) frame_err++;  // one stop bit
    rx_q.push_back(shift);
    start_q.push_back(t_start);
  end

  // ==========================================================
  // transmit side
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};  // start, data lsb first, stop
    @(negedge i_sys_clk);
    for (int i = 0; i < 10; i++) begin
      o_rxd = fr[i];
      repeat (P_BIT_CYCLES) @(negedge i_sys_clk);
    end
  endtask

  task automatic send_line(input string s);
    for (int i = 0; i < s.len(); i++) begin
      send_byte(s[i]);  // lower-case letters as given
    end
    send_byte(CH_CR);  // enter terminator
  endtask
endmodule

// File: bench/tb_top.sv
// Purpose: self-checking bench of the serial status reporter
// Assumes: short bit and report periods set by parameter
// Notes:   report text is judged char by char against the ordered items
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin tests_run++; if ((ex) !== (gt)) begin failures++; \
  $display("[ERR] %s expected %0h seen %0h", nm, ex, gt); end end
module tb_top
  import ssr_pkg::*;
;
  // ==========================================================
  // setup
  localparam int    BITN = 16;
  localparam int    RPT  = 12000;  // must exceed the longest report
  localparam string CRLF = "\015\012";
  logic        i_sys_clk;
  logic        i_rst_b;
  logic        i_rxd;
  logic        o_txd;
  logic [15:0] i_conc_bcd;
  logic        i_conc_pct;
  logic [1:0]  i_range;
  logic [15:0] i_span_bcd;
  logic [1:0]  i_alarm_dis;
  logic [1:0]  i_alarm_trip;
  logic        o_autospan_start;
  logic        o_autozero_start;
  logic        o_report_enable;
  int          failures  = 0;
  int          tests_run = 0;
  int          span_cnt  = 0;
  int          zero_cnt  = 0;
  int          t1;
  int          t2;

  initial i_sys_clk = 1'b0;
  always #2 i_sys_clk = ~i_sys_clk;

  ssr_top #(.P_BIT_CYCLES(BITN), .P_REPORT_CYCLES(RPT)) dut (
    .i_sys_clk       (i_sys_clk),
    .i_rst_b         (i_rst_b),
    .i_rxd           (i_rxd),
    .o_txd           (o_txd),
    .i_conc_bcd      (i_conc_bcd),
    .i_conc_pct      (i_conc_pct),
    .i_range         (i_range),
    .i_span_bcd      (i_span_bcd),
    .i_alarm_dis     (i_alarm_dis),
    .i_alarm_trip    (i_alarm_trip),
    .o_autospan_start(o_autospan_start),
    .o_autozero_start(o_autozero_start),
    .o_report_enable (o_report_enable)
  );

  ssr_host #(.P_BIT_CYCLES(BITN)) host (
    .i_sys_clk(i_sys_clk),
    .i_txd    (o_txd),
    .o_rxd    (i_rxd)
  );

  // counts high cycles, so a stretched pulse shows as an extra count
  // sampled mid-cycle, where the registered pulse has settled
  always @(negedge i_sys_clk) begin
    if (o_autospan_start === 1'b1) span_cnt++;
    if (o_autozero_start === 1'b1) zero_cnt++;
  end

  // ==========================================================
  // shared tasks
  task conclude;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task set_in(input logic [15:0] c, input logic p, input logic [1:0] r,
              input logic [15:0] s, input logic [1:0] d, input logic [1:0] t);
    @(negedge i_sys_clk);
    i_conc_bcd   = c;
    i_conc_pct   = p;
    i_range      = r;
    i_span_bcd   = s;
    i_alarm_dis  = d;
    i_alarm_trip = t;
  endtask

  task automatic get_report(input string ex, output int t0);
    int k;
    host.rx_q.delete();
    host.start_q.delete();
    k = 0;
    while (host.rx_q.size() < ex.len() && k < 3 * RPT) begin
      @(negedge i_sys_clk);
      k++;
    end
    if (k >= 3 * RPT) begin
      failures++;
      $display("[ERR] report length expected %0d seen %0d", ex.len(), host.rx_q.size());
      conclude();
    end
    for (int i = 0; i < ex.len(); i++) begin
      `CHK("report char", ex[i], host.rx_q[i]);
    end
    `CHK("frame errors", 0, host.frame_err);
    t0 = host.start_q[0];
  endtask

  // ==========================================================
  // scenarios
  task t_reset;
    @(negedge i_sys_clk);
    `CHK("txd idle", 1'b1, o_txd);
    `CHK("enable at reset", 1'b1, o_report_enable);
    `CHK("span pulse", 1'b0, o_autospan_start);
    `CHK("zero pulse", 1'b0, o_autozero_start);
  endtask

  // command arrives while the full report goes out
  task t_full_duplex;
    string e;
    e = {"1234PPM", CRLF, "HI", CRLF, "0-0100", CRLF, "AL-1 DISABLED", CRLF,
         "AL-2 DISABLED", CRLF, "AL-1 ON", CRLF, "AL-2 ON", CRLF};
    fork
      get_report(e, t1);
      begin
        // hold the command back until the report has run about 1000 cycles
        repeat (RPT + 1000) @(negedge i_sys_clk);
        host.send_line("as");
      end
    join
    `CHK("span starts", 1, span_cnt);
    `CHK("zero starts", 0, zero_cnt);
  endtask

  task t_interval;
    string e;
    set_in(16'h0095, 1'b1, 2'h1, 16'h0100, 2'h0, 2'h0);
    e = {"0095%", CRLF, "MED", CRLF, "0-0100", CRLF};
    get_report(e, t2);
    `CHK("interval", 1'b1, (t2 - t1 >= RPT - 2) && (t2 - t1 <= RPT + 2));
  endtask

  task t_commands;
    host.send_line("az");
    `CHK("zero starts", 1, zero_cnt);
    host.send_line("aa");
    host.send_line("ast");
    host.send_line("s");
    host.send_line("sa");
    repeat (4) @(negedge i_sys_clk);
    `CHK("span after junk", 1, span_cnt);
    `CHK("zero after junk", 1, zero_cnt);
    `CHK("enable after junk", 1'b1, o_report_enable);
    host.send_line("\012a\012s");
    `CHK("span with line feeds", 2, span_cnt);
  endtask

  task t_toggle;
    host.send_line("st");
    `CHK("enable off", 1'b0, o_report_enable);
    host.rx_q.delete();
    repeat (RPT + 500) @(negedge i_sys_clk);
    `CHK("silent while off", 0, host.rx_q.size());
    host.send_line("st");
    `CHK("enable on", 1'b1, o_report_enable);
  endtask

  // remaining range codes and single alarm tags
  task t_ranges;
    string e;
    set_in(16'h0007, 1'b1, 2'h0, 16'h0250, 2'b01, 2'b10);
    e = {"0007%", CRLF, "LO", CRLF, "0-0250", CRLF, "AL-1 DISABLED", CRLF, "AL-2 ON", CRLF};
    get_report(e, t1);
    set_in(16'h9999, 1'b0, 2'h3, 16'h2500, 2'b10, 2'b01);
    e = {"9999PPM", CRLF, "LO", CRLF, "0-2500", CRLF, "AL-2 DISABLED", CRLF, "AL-1 ON", CRLF};
    get_report(e, t2);
    `CHK("interval resumed", 1'b1, (t2 - t1 >= RPT - 2) && (t2 - t1 <= RPT + 2));
  endtask

  // ==========================================================
  // main sequence
  initial begin
    i_rst_b = 1'b0;
    set_in(16'h1234, 1'b0, 2'h2, 16'h0100, 2'b11, 2'b11);
    repeat (5) @(posedge i_sys_clk);
    t_reset();
    i_rst_b = 1'b1;
    t_full_duplex();
    t_interval();
    t_commands();
    t_toggle();
    t_ranges();
    conclude();
  end
endmodule
